// ### verilog/hce_dma_engines.sv
// iso transmit, iso receive and async send dma engines sharing one bus master port
// Notes on behaviour
// - iso transmit has eight independently configured contexts, each its own channel.
// - every iso cycle each context is visited, one packet per active one.
// - inactive transmit contexts are skipped with no bus activity.
// - active context: request bus, read descriptor, decode length and address, read payload.
// - after each serviced context a cycle marker word enters the transmit fifo.
// - iso receive has eight independently controlled contexts, each bound to one channel.
// - software may pick one receive context that accepts several channels.
// - first receive fifo word is popped as header; channel and filters extracted.
// - header is compared against every receive context's settings.
// - on match: request bus, fetch descriptor, write packet words to host memory.
// - no match: packet is drained from the fifo without memory access.
// - a local arbiter picks which engine gets the bus master port.
// - slave reads are decoded and data taken from the addressed source.
// - engine interrupt conditions are gathered onto the host interrupt.
// - iso status is held and forwarded to the interrupt handler.
// - async status is held and forwarded to the interrupt handler.
// - request and response contexts behave alike, each with its own descriptor list.
// - async send: descriptor, payload to fifo, link send, retries, errors, finish.
// - engines act as bus master for descriptors and data, answer slave reads.
`timescale 1ns/1ns
`include "hce_defs.svh"
module hce_dma_engines
	import hce_pkg::*;
#(
	parameter int CTX = `HCE_CTX_NUM,
	parameter logic [3:0] RETRY_MAX = `HCE_RETRY_MAX
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cycle_start,
	input wire logic [CTX-1:0] it_ctx_active,
	input wire logic [CTX*32-1:0] it_desc_ptr,
	input wire logic [CTX-1:0] ir_ctx_active,
	input wire logic [CTX*6-1:0] ir_ctx_chan,
	input wire logic [CTX*4-1:0] ir_ctx_tag_mask,
	input wire logic [CTX*32-1:0] ir_desc_ptr,
	input wire logic ir_multi_en,
	input wire logic [2:0] ir_multi_sel,
	input wire logic [63:0] ir_chan_mask,
	input wire logic at_req_go,
	input wire logic [31:0] at_req_ptr,
	input wire logic at_rsp_go,
	input wire logic [31:0] at_rsp_ptr,
	output logic at_req_done,
	output logic at_rsp_done,
	output logic mst_req,
	output logic mst_we,
	output logic [31:0] mst_addr,
	output logic [31:0] mst_wdata,
	input wire logic mst_ack,
	input wire logic mst_err,
	input wire logic [31:0] mst_rdata,
	output logic [31:0] fifo_wdata,
	output logic it_fifo_valid,
	input wire logic it_fifo_ready,
	output logic at_fifo_valid,
	input wire logic at_fifo_ready,
	input wire logic rx_fifo_valid,
	input wire logic [31:0] rx_fifo_data,
	output logic rx_fifo_ready,
	output logic link_send_req,
	input wire logic link_send_done,
	input wire logic link_send_retry,
	input wire logic link_send_err,
	input wire logic slave_rd,
	input wire logic [3:0] slave_addr,
	output logic [31:0] slave_rdata,
	output logic slave_rvalid,
	input wire logic [2:0] iso_stat_clr,
	input wire logic [1:0] async_stat_clr,
	output logic pci_int_n
);
	hce_state_type state_q, state_d;
	hce_kind_type kind_q, kind_d;
	logic [31:0] addr_q, addr_d, hold_q, hold_d;
	logic hold_vld_q, hold_vld_d, it_pend_q, it_pend_d;
	logic [15:0] cnt_q, cnt_d;
	logic [2:0] it_idx_q, it_idx_d;
	logic [3:0] retry_q, retry_d;
	logic [2:0] iso_stat_q, iso_stat_d, iso_ev;
	logic [1:0] async_stat_q, async_stat_d, async_ev;
	logic [31:0] srd_q, srd_d;
	logic srv_q, int_n_q;
	logic [5:0] hdr_chan;
	logic [1:0] hdr_tag;
	logic [CTX-1:0] ir_hit;
	logic ir_any;
	logic [2:0] ir_sel;
	logic bus_state;

	assign hdr_chan = rx_fifo_data[`HCE_HDR_CHAN_LSB +: 6];
	assign hdr_tag = rx_fifo_data[`HCE_HDR_TAG_LSB +: 2];

	// ----------------------------------------
	// receive context matching
	// ----------------------------------------
	for (genvar g = 0; g < CTX; g++)
	begin : g_match
		// per context channel and tag filter
		// the chosen context listens to a channel mask instead
		assign ir_hit[g] = ir_ctx_active[g] && ir_ctx_tag_mask[g*4 + int'(hdr_tag)] &&
			((ir_multi_en && ir_multi_sel == 3'(g)) ? ir_chan_mask[hdr_chan] : (ir_ctx_chan[g*6 +: 6] == hdr_chan));
	end

	// lowest numbered matching context wins when several claim a packet
	always_comb
	begin
		ir_sel = 3'h0;
		for (int i = CTX - 1; i >= 0; i--)
		begin
			if (ir_hit[i])
				ir_sel = 3'(i);
		end
	end
	assign ir_any = |ir_hit;
	assign bus_state = state_q inside {ST_DESC0, ST_DESC1, ST_MOVE};

	// ----------------------------------------
	// shared sequencer
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		kind_d = kind_q;
		addr_d = addr_q;
		hold_d = hold_q;
		hold_vld_d = hold_vld_q;
		cnt_d = cnt_q;
		it_idx_d = it_idx_q;
		retry_d = retry_q;
		// a new cycle re-arms the visit; set wins over the wrap clear
		it_pend_d = it_pend_q;
		iso_ev = 3'h0;
		async_ev = 2'h0;
		mst_req = 1'b0;
		mst_we = 1'b0;
		rx_fifo_ready = 1'b0;
		link_send_req = 1'b0;
		at_req_done = 1'b0;
		at_rsp_done = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				retry_d = 4'h0;
				// arbiter: receive first since its fifo cannot wait, then transmit, then async
				if (rx_fifo_valid)
				begin
					// pop the header word and take its length
					rx_fifo_ready = 1'b1;
					cnt_d = rx_fifo_data[`HCE_HDR_LEN_LSB +: 16];
					kind_d = K_IR;
					if (ir_any)
					begin
						// matched packet goes through a descriptor
						addr_d = ir_desc_ptr[ir_sel*32 +: 32];
						state_d = ST_DESC0;
					end
					else
					begin
						state_d = ST_DRAIN;
					end
				end
				else if (it_pend_q)
				begin
					kind_d = K_IT;
					// each context has its own descriptor pointer
					addr_d = it_desc_ptr[it_idx_q*32 +: 32];
					if (it_ctx_active[it_idx_q])
						state_d = ST_DESC0;
					else
					begin
						it_idx_d = it_idx_q + 3'h1;
						if (it_idx_q == 3'(CTX - 1))
							it_pend_d = 1'b0;
					end
				end
				else if (at_req_go || at_rsp_go)
				begin
					// same path, only the descriptor list differs
					kind_d = at_req_go ? K_ATQ : K_ATR;
					addr_d = at_req_go ? at_req_ptr : at_rsp_ptr;
					state_d = ST_DESC0;
				end
			end
			ST_DESC0:
			begin
				// descriptor word 0 holds the payload length, except receive which keeps the header length
				mst_req = 1'b1;
				if (mst_ack)
				begin
					addr_d = addr_q + `HCE_WORD_STEP;
					if (kind_q != K_IR)
						cnt_d = mst_rdata[15:0];
					state_d = ST_DESC1;
				end
			end
			ST_DESC1:
			begin
				// descriptor word 1 holds the host address
				mst_req = 1'b1;
				if (mst_ack)
				begin
					addr_d = mst_rdata;
					state_d = ST_MOVE;
				end
			end
			ST_MOVE:
			begin
				if (kind_q == K_IR)
				begin
					// one fifo word per write beat
					if (!hold_vld_q && cnt_q != 16'h0)
					begin
						rx_fifo_ready = rx_fifo_valid;
						if (rx_fifo_valid)
						begin
							hold_d = rx_fifo_data;
							hold_vld_d = 1'b1;
							cnt_d = cnt_q - 16'h1;
						end
					end
					mst_req = hold_vld_q;
					mst_we = 1'b1;
					if (mst_ack)
					begin
						hold_vld_d = 1'b0;
						addr_d = addr_q + `HCE_WORD_STEP;
					end
					if (!hold_vld_q && cnt_q == 16'h0)
					begin
						iso_ev[`HCE_ISO_IR_DONE] = 1'b1;
						state_d = ST_IDLE;
					end
				end
				else
				begin
					// next read only once the held word is in the fifo
					mst_req = !hold_vld_q && cnt_q != 16'h0;
					if (mst_ack)
					begin
						hold_d = mst_rdata;
						hold_vld_d = 1'b1;
						addr_d = addr_q + `HCE_WORD_STEP;
						cnt_d = cnt_q - 16'h1;
					end
					if (hold_vld_q && (kind_q == K_IT ? it_fifo_ready : at_fifo_ready))
						hold_vld_d = 1'b0;
					if (!hold_vld_q && cnt_q == 16'h0)
					begin
						if (kind_q == K_IT)
						begin
							// marker closes this context's share of the cycle
							hold_d = `HCE_CYCLE_MARKER;
							hold_vld_d = 1'b1;
							state_d = ST_MARK;
						end
						else
							state_d = ST_LINK;
					end
				end
				// a bus error abandons the packet and is reported
				if (mst_err)
				begin
					hold_vld_d = 1'b0;
					if (kind_q == K_ATQ || kind_q == K_ATR)
						async_ev[`HCE_ASYNC_ERR] = 1'b1;
					else
						iso_ev[`HCE_ISO_ERR] = 1'b1;
					state_d = (kind_q == K_IT) ? ST_MARK : ST_IDLE;
					if (kind_q == K_IT)
					begin
						hold_d = `HCE_CYCLE_MARKER;
						hold_vld_d = 1'b1;
					end
				end
			end
			ST_MARK:
			begin
				if (it_fifo_ready)
				begin
					hold_vld_d = 1'b0;
					iso_ev[`HCE_ISO_IT_DONE] = 1'b1;
					it_idx_d = it_idx_q + 3'h1;
					if (it_idx_q == 3'(CTX - 1))
						it_pend_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			ST_LINK:
			begin
				// ask the link to send, retry on busy up to the limit
				link_send_req = 1'b1;
				if (link_send_done)
				begin
					if (link_send_retry && !link_send_err && retry_q < RETRY_MAX)
						retry_d = retry_q + 4'h1;
					else
					begin
						if (link_send_err || link_send_retry)
							async_ev[`HCE_ASYNC_ERR] = 1'b1;
						else
							async_ev[`HCE_ASYNC_DONE] = 1'b1;
						at_req_done = kind_q == K_ATQ;
						at_rsp_done = kind_q == K_ATR;
						state_d = ST_IDLE;
					end
				end
			end
			ST_DRAIN:
			begin
				rx_fifo_ready = rx_fifo_valid && cnt_q != 16'h0;
				if (rx_fifo_ready)
					cnt_d = cnt_q - 16'h1;
				if (cnt_q == 16'h0)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
		if (mst_err && (state_q == ST_DESC0 || state_q == ST_DESC1))
		begin
			state_d = ST_IDLE;
			if (kind_q == K_ATQ || kind_q == K_ATR)
				async_ev[`HCE_ASYNC_ERR] = 1'b1;
			else
				iso_ev[`HCE_ISO_ERR] = 1'b1;
			// a failed receive descriptor still must empty the packet
			if (kind_q == K_IR)
				state_d = ST_DRAIN;
			if (kind_q == K_IT)
			begin
				hold_d = `HCE_CYCLE_MARKER;
				hold_vld_d = 1'b1;
				state_d = ST_MARK;
			end
		end
		if (cycle_start)
		begin
			it_pend_d = 1'b1;
			if (!it_pend_q)
				it_idx_d = 3'h0;
		end
	end

	// ----------------------------------------
	// status, interrupt and slave read
	// ----------------------------------------
	always_comb
	begin
		// iso status held; a new event wins over its clear
		iso_stat_d = (iso_stat_q & ~iso_stat_clr) | iso_ev;
		// async status held the same way
		async_stat_d = (async_stat_q & ~async_stat_clr) | async_ev;
		// decode the slave address and pick the source
		unique case (slave_addr)
			`HCE_SEL_ISO_STAT: srd_d = {29'h0, iso_stat_q};
			`HCE_SEL_ASYNC_STAT: srd_d = {30'h0, async_stat_q};
			`HCE_SEL_ENGINE: srd_d = {16'h0, it_pend_q, it_idx_q, kind_q, 3'h0, state_q};
			default: srd_d = 32'h0;
		endcase
		if (!slave_rd)
			srd_d = slave_rdata;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_IDLE;
			kind_q <= K_IT;
			addr_q <= 32'h0;
			hold_q <= 32'h0;
			hold_vld_q <= 1'b0;
			cnt_q <= 16'h0;
			it_idx_q <= 3'h0;
			it_pend_q <= 1'b0;
			retry_q <= 4'h0;
			iso_stat_q <= 3'h0;
			async_stat_q <= 2'h0;
			srd_q <= 32'h0;
			srv_q <= 1'b0;
			int_n_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			addr_q <= addr_d;
			hold_q <= hold_d;
			hold_vld_q <= hold_vld_d;
			cnt_q <= cnt_d;
			it_idx_q <= it_idx_d;
			it_pend_q <= it_pend_d;
			retry_q <= retry_d;
			iso_stat_q <= iso_stat_d;
			async_stat_q <= async_stat_d;
			srd_q <= srd_d;
			srv_q <= slave_rd;
			// any held status asserts the host interrupt
			int_n_q <= !(|{iso_stat_d, async_stat_d});
		end
	end

	// master address and data straight from flops
	assign mst_addr = addr_q;
	assign mst_wdata = hold_q;
	assign fifo_wdata = hold_q;
	assign it_fifo_valid = hold_vld_q && kind_q == K_IT && (state_q == ST_MOVE || state_q == ST_MARK);
	assign at_fifo_valid = hold_vld_q && (kind_q == K_ATQ || kind_q == K_ATR) && state_q == ST_MOVE;
	assign slave_rdata = srd_q;
	assign slave_rvalid = srv_q;
	assign pci_int_n = int_n_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_skip_no_bus: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_IDLE && !rx_fifo_valid && it_pend_q && !it_ctx_active[it_idx_q]
		|=> state_q == ST_IDLE && !mst_req && it_idx_q == $past(it_idx_q) + 3'h1)
		else $error("inactive context not skipped");
	a_desc_then_data: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_DESC1 && mst_ack && !mst_err |=> state_q == ST_MOVE && mst_addr == $past(mst_rdata))
		else $error("payload address not taken from descriptor");
	a_marker_word: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_MARK |-> it_fifo_valid && fifo_wdata == `HCE_CYCLE_MARKER)
		else $error("cycle marker missing");
	a_header_pop: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_IDLE && rx_fifo_valid |-> rx_fifo_ready ##1 (state_q == ST_DESC0 || state_q == ST_DRAIN))
		else $error("header not popped");
	a_drain_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_DRAIN |-> !mst_req)
		else $error("drain touched memory");
	a_master_busy: assert property (@(posedge clk) disable iff (!reset_n)
		mst_req |-> bus_state && (mst_we == (state_q == ST_MOVE && kind_q == K_IR)))
		else $error("bus request outside a transfer");
	a_fifo_stall: assert property (@(posedge clk) disable iff (!reset_n)
		it_fifo_valid && !it_fifo_ready |=> it_fifo_valid && $stable(fifo_wdata) && !mst_req)
		else $error("word lost under back-pressure");
	a_retry_limit: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_LINK && link_send_done && link_send_retry && retry_q == RETRY_MAX
		|=> state_q == ST_IDLE && async_stat_q[`HCE_ASYNC_ERR])
		else $error("retry limit not enforced");
	a_int_raise: assert property (@(posedge clk) disable iff (!reset_n)
		|async_ev |=> !pci_int_n)
		else $error("async event gave no interrupt");
endmodule : hce_dma_engines

// ### verilog/hce_defs.svh
// constants of the host controller dma engines
`ifndef HCE_DEFS_SVH
`define HCE_DEFS_SVH
`define HCE_CTX_NUM 8
`define HCE_HDR_LEN_LSB 16
`define HCE_HDR_TAG_LSB 14
`define HCE_HDR_CHAN_LSB 8
`define HCE_WORD_STEP 32'h0000_0004
`define HCE_CYCLE_MARKER 32'hffff_0000
`define HCE_RETRY_MAX 4'h3
`define HCE_SEL_ISO_STAT 4'h0
`define HCE_SEL_ASYNC_STAT 4'h1
`define HCE_SEL_ENGINE 4'h2
`define HCE_ISO_IT_DONE 0
`define HCE_ISO_IR_DONE 1
`define HCE_ISO_ERR 2
`define HCE_ASYNC_DONE 0
`define HCE_ASYNC_ERR 1
`endif

// ### verilog/hce_pkg.sv
// types of the host controller dma engines
package hce_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DESC0 = 7'h02,
		ST_DESC1 = 7'h04,
		ST_MOVE = 7'h08,
		ST_MARK = 7'h10,
		ST_LINK = 7'h20,
		ST_DRAIN = 7'h40
	} hce_state_type;
	typedef enum logic [1:0] {
		K_IT = 2'h0,
		K_IR = 2'h1,
		K_ATQ = 2'h2,
		K_ATR = 2'h3
	} hce_kind_type;
endpackage : hce_pkg

// ### bench/hce_host_mem.sv
// host memory model answering the dma engines' bus master port
`timescale 1ns/1ns
module hce_host_mem (
	input wire logic clk,
	input wire logic mst_req,
	input wire logic mst_we,
	input wire logic [31:0] mst_addr,
	input wire logic [31:0] mst_wdata,
	input wire logic [3:0] lat,
	input wire logic [31:0] err_addr,
	output logic mst_ack,
	output logic mst_err,
	output logic [31:0] mst_rdata,
	output int n_acc,
	output int n_wr
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] a_q;
	logic [31:0] d_q;
	logic we_q;
	logic was;
	int cnt;
	initial
	begin
		mst_ack = 1'b0;
		mst_err = 1'b0;
		mst_rdata = 32'h5a5a_a5a5;
		n_acc = 0;
		n_wr = 0;
		cnt = 0;
	end
	// ------------------------------------------
	// one word per access, answered after lat idle cycles
	// ------------------------------------------
	always @(posedge clk)
	begin
		was = mst_ack;
		if (was)
		begin
			n_acc++;
			if (we_q)
			begin
				mem[a_q] = d_q;
				n_wr++;
			end
		end
		#1;
		if (!was && mst_req && cnt >= lat)
		begin
			// the request is held until ack, so capture it now
			a_q = mst_addr;
			d_q = mst_wdata;
			we_q = mst_we;
			// a matching address answers with a bus error instead of an ack
			mst_err = mst_addr == err_addr;
			mst_ack = !mst_err;
			mst_rdata = mem.exists(mst_addr) ? mem[mst_addr] : 32'h0;
			cnt = 0;
		end
		else
		begin
			// released data is scrambled so stale reads show up
			mst_ack = 1'b0;
			mst_err = 1'b0;
			mst_rdata = ~mst_rdata;
			if (mst_req && !was)
				cnt++;
		end
	end
endmodule : hce_host_mem

// ### bench/host_controller_dma_engines_tb.sv
// self-checking testbench of the dma engines
`timescale 1ns/1ns
`include "hce_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module host_controller_dma_engines_tb;
	import hce_pkg::*;
	logic clk = 0, reset_n = 0, cycle_start = 0, ir_multi_en = 0, at_req_go = 0, at_rsp_go = 0;
	logic [7:0] it_ctx_active = 0, ir_ctx_active = 0;
	logic [255:0] it_desc_ptr = 0, ir_desc_ptr = 0;
	logic [47:0] ir_ctx_chan = 0;
	logic [31:0] ir_ctx_tag_mask = 0, at_req_ptr = 0, at_rsp_ptr = 0, rx_fifo_data = 0, fifo_wdata, mst_addr;
	logic [31:0] mst_wdata, mst_rdata, slave_rdata;
	logic [2:0] ir_multi_sel = 0, iso_stat_clr = 0;
	logic [1:0] async_stat_clr = 0;
	logic [63:0] ir_chan_mask = 0;
	logic [3:0] slave_addr = 0, lat = 0;
	logic [31:0] err_addr = 32'hffff_fffc;
	logic it_fifo_ready = 1, at_fifo_ready = 1, rx_fifo_valid = 0, link_send_done = 0, link_send_retry = 0;
	logic link_send_err = 0, slave_rd = 0, stall = 0, rx_fire = 0, req_seen = 0, rsp_seen = 0;
	logic at_req_done, at_rsp_done, mst_req, mst_we, mst_ack, mst_err, it_fifo_valid, at_fifo_valid;
	logic rx_fifo_ready, link_send_req, slave_rvalid, pci_int_n;
	logic [31:0] itq [$], atq [$], rxq [$];
	int err_total = 0, checked = 0, cyc = 0, n_acc, n_wr, a0;
	hce_dma_engines dut (.clk(clk), .reset_n(reset_n), .cycle_start(cycle_start),
		.it_ctx_active(it_ctx_active), .it_desc_ptr(it_desc_ptr), .ir_ctx_active(ir_ctx_active),
		.ir_ctx_chan(ir_ctx_chan), .ir_ctx_tag_mask(ir_ctx_tag_mask), .ir_desc_ptr(ir_desc_ptr),
		.ir_multi_en(ir_multi_en), .ir_multi_sel(ir_multi_sel), .ir_chan_mask(ir_chan_mask),
		.at_req_go(at_req_go), .at_req_ptr(at_req_ptr), .at_rsp_go(at_rsp_go), .at_rsp_ptr(at_rsp_ptr),
		.at_req_done(at_req_done), .at_rsp_done(at_rsp_done), .mst_req(mst_req), .mst_we(mst_we),
		.mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_ack(mst_ack), .mst_err(mst_err),
		.mst_rdata(mst_rdata), .fifo_wdata(fifo_wdata), .it_fifo_valid(it_fifo_valid),
		.it_fifo_ready(it_fifo_ready), .at_fifo_valid(at_fifo_valid), .at_fifo_ready(at_fifo_ready),
		.rx_fifo_valid(rx_fifo_valid), .rx_fifo_data(rx_fifo_data), .rx_fifo_ready(rx_fifo_ready),
		.link_send_req(link_send_req), .link_send_done(link_send_done), .link_send_retry(link_send_retry),
		.link_send_err(link_send_err), .slave_rd(slave_rd), .slave_addr(slave_addr),
		.slave_rdata(slave_rdata), .slave_rvalid(slave_rvalid), .iso_stat_clr(iso_stat_clr),
		.async_stat_clr(async_stat_clr), .pci_int_n(pci_int_n));
	hce_host_mem hm (.clk(clk), .mst_req(mst_req), .mst_we(mst_we), .mst_addr(mst_addr),
		.mst_wdata(mst_wdata), .lat(lat), .err_addr(err_addr), .mst_ack(mst_ack), .mst_err(mst_err),
		.mst_rdata(mst_rdata), .n_acc(n_acc), .n_wr(n_wr));
	// ------------------------------------------
	// clock, fifo sides and monitors
	// ------------------------------------------
	always #50 clk = ~clk;
	always @(negedge clk)
	begin
		if (it_fifo_valid && it_fifo_ready)
			itq.push_back(fifo_wdata);
		if (at_fifo_valid && at_fifo_ready)
			atq.push_back(fifo_wdata);
		rx_fire = rx_fifo_valid && rx_fifo_ready;
		req_seen |= at_req_done;
		rsp_seen |= at_rsp_done;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			test_done();
		end
		#1;
		if (rx_fire)
			void'(rxq.pop_front());
		rx_fire = 0;
		rx_fifo_valid = rxq.size() > 0;
		rx_fifo_data = rxq.size() > 0 ? rxq[0] : ~rx_fifo_data;
		it_fifo_ready = stall ? ~it_fifo_ready : 1'b1;
		at_fifo_ready = stall ? ~at_fifo_ready : 1'b1;
	end
	task tk(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk
	task rd(logic [3:0] a, logic [31:0] e);
		slave_rd = 1;
		slave_addr = a;
		tk(1);
		slave_rd = 0;
		`CHK(slave_rvalid, 1'b1)
		`CHK(slave_rdata, e)
		// let an edge pass so back-to-back reads show a low strobe
		tk(1);
	endtask : rd
	task link(logic r, logic e, logic last);
		// one quiet edge between two link answers
		tk(1);
		for (int i = 0; i < 300 && link_send_req !== 1'b1; i++)
			tk(1);
		`CHK(link_send_req, 1'b1)
		{link_send_done, link_send_retry, link_send_err} = {1'b1, r, e};
		if (last)
			{at_req_go, at_rsp_go} = 2'b00;
		tk(1);
		{link_send_done, link_send_retry, link_send_err} = 3'b000;
	endtask : link
	// ------------------------------------------
	// scenarios
	// ------------------------------------------
	task t_it;
		hm.mem[32'h100] = 32'h2;
		hm.mem[32'h104] = 32'h1000;
		hm.mem[32'h1000] = 32'ha0a0_0001;
		hm.mem[32'h1004] = 32'ha0a0_0002;
		hm.mem[32'h200] = 32'h1;
		hm.mem[32'h204] = 32'h2000;
		hm.mem[32'h2000] = 32'hb0b0_0001;
		it_desc_ptr[31:0] = 32'h100;
		it_desc_ptr[95:64] = 32'h200;
		it_desc_ptr[63:32] = 32'h300;
		it_ctx_active = 8'h05;
		{stall, lat} = {1'b1, 4'h2};
		a0 = n_acc;
		cycle_start = 1;
		tk(1);
		cycle_start = 0;
		for (int i = 0; i < 400 && itq.size() < 5; i++)
			tk(1);
		tk(20);
		// inactive contexts skipped, stalls lose nothing
		`CHK(itq.size(), 5)
		`CHK(n_acc - a0, 7)
		`CHK({itq[0], itq[1], itq[3]}, {32'ha0a0_0001, 32'ha0a0_0002, 32'hb0b0_0001})
		`CHK({itq[2], itq[4]}, {`HCE_CYCLE_MARKER, `HCE_CYCLE_MARKER})
		`CHK(pci_int_n, 1'b0)
		rd(`HCE_SEL_ISO_STAT, 32'h1);
		iso_stat_clr = 3'h7;
		tk(1);
		iso_stat_clr = 0;
		tk(2);
		`CHK(pci_int_n, 1'b1)
		{stall, lat, it_ctx_active} = 0;
		$display("test it done");
	endtask : t_it
	task rx(logic [15:0] n, logic [1:0] tg, logic [5:0] ch);
		rxq.push_back({n, tg, ch, 8'h00});
		for (int i = 0; i < n; i++)
			rxq.push_back(32'hc0c0_0000 + 32'(i) + {16'h0, 2'h0, ch, 8'h0});
		for (int i = 0; i < 300 && (rxq.size() > 0 || rx_fifo_valid); i++)
			tk(1);
		tk(10);
	endtask : rx
	task t_ir;
		ir_ctx_active = 8'h18;
		ir_ctx_chan[23:18] = 6'd5;
		ir_ctx_tag_mask[15:12] = 4'h1;
		ir_ctx_tag_mask[19:16] = 4'hf;
		ir_desc_ptr[127:96] = 32'h300;
		ir_desc_ptr[159:128] = 32'h400;
		hm.mem[32'h304] = 32'h3000;
		hm.mem[32'h404] = 32'h4000;
		{ir_multi_en, ir_multi_sel} = {1'b1, 3'h4};
		ir_chan_mask[40] = 1'b1;
		lat = 1;
		rx(16'h2, 2'h0, 6'd5);
		`CHK({hm.mem[32'h3000], hm.mem[32'h3004]}, {32'hc0c0_0500, 32'hc0c0_0501})
		rx(16'h1, 2'h2, 6'd40);
		`CHK(hm.mem[32'h4000], 32'hc0c0_2800)
		a0 = n_acc;
		// tag refused by ctx 3, channel 9 unbound: drained only
		rx(16'h2, 2'h1, 6'd5);
		rx(16'h3, 2'h0, 6'd9);
		`CHK(n_acc - a0, 0)
		`CHK(rx_fifo_valid, 1'b0)
		`CHK(n_wr, 3)
		rd(`HCE_SEL_ISO_STAT, 32'h2);
		iso_stat_clr = 3'h7;
		tk(1);
		iso_stat_clr = 0;
		$display("test ir done");
	endtask : t_ir
	task t_at;
		hm.mem[32'h500] = 32'h1;
		hm.mem[32'h504] = 32'h5000;
		hm.mem[32'h5000] = 32'hd0d0_0001;
		hm.mem[32'h600] = 32'h1;
		hm.mem[32'h604] = 32'h6000;
		hm.mem[32'h6000] = 32'hd0d0_0002;
		{at_req_ptr, at_rsp_ptr, stall} = {32'h500, 32'h600, 1'b1};
		at_req_go = 1;
		link(1'b1, 1'b0, 1'b0);
		link(1'b0, 1'b0, 1'b1);
		`CHK(req_seen, 1'b1)
		at_rsp_go = 1;
		link(1'b0, 1'b1, 1'b1);
		`CHK(rsp_seen, 1'b1)
		`CHK({atq.size(), atq[0], atq[1]}, {32'd2, 32'hd0d0_0001, 32'hd0d0_0002})
		// retries up to the limit, then one more busy answer ends in error
		at_req_go = 1;
		repeat (3) link(1'b1, 1'b0, 1'b0);
		link(1'b1, 1'b0, 1'b1);
		`CHK(atq.size(), 3)
		rd(`HCE_SEL_ASYNC_STAT, 32'h3);
		rd(4'hf, 32'h0);
		rd(`HCE_SEL_ENGINE, 32'h0000_0801);
		stall = 0;
		$display("test at done");
	endtask : t_at
	task t_err;
		err_addr = 32'h2000;
		it_ctx_active = 8'h04;
		a0 = itq.size();
		cycle_start = 1;
		tk(1);
		cycle_start = 0;
		tk(40);
		// a failed payload read still closes the context with a marker
		`CHK(itq.size() - a0, 1)
		`CHK(itq[a0], `HCE_CYCLE_MARKER)
		rd(`HCE_SEL_ISO_STAT, 32'h5);
		{iso_stat_clr, err_addr, it_ctx_active} = {3'h7, 32'hffff_fffc, 8'h0};
		tk(1);
		iso_stat_clr = 0;
		$display("test err done");
	endtask : t_err
	task test_done;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial
	begin
		tk(6);
		reset_n = 1;
		tk(2);
		t_it();
		t_err();
		t_ir();
		t_at();
		test_done();
	end
endmodule : host_controller_dma_engines_tb
